/* File: sync_trigger_station_consts.vh */
// register offsets, field positions, reset values and timing counts of the sync trigger station
`ifndef SYNC_TRIGGER_STATION_CONSTS_VH
`define SYNC_TRIGGER_STATION_CONSTS_VH

`define OFS_CTRL 8'h00
`define OFS_START_IN 8'h04
`define OFS_STOP_IN 8'h08
`define OFS_START_OUT 8'h0c
`define OFS_STOP_OUT 8'h10
`define OFS_STATUS 8'h14
`define OFS_CMD 8'h18

`define CTRL_ARM 0
`define CMD_START 0
`define CMD_STOP 1

`define IN_LINE_LSB 0
`define IN_FIRST_LSB 8
`define IN_FACTOR_LSB 16
`define IN_ONCE 24
`define IN_MASK 32'h01ffff03

`define OUT_LINE_LSB 0
`define OUT_NEG 4
`define OUT_ONCE 5
`define OUT_EN 6
`define OUT_WIDTH_LSB 8
`define OUT_FIRST_LSB 16
`define OUT_FACTOR_LSB 24
`define OUT_MASK 32'hffff7f73

`define RST_CTRL 32'h00000000
`define RST_IN_CFG 32'h00000000
`define RST_OUT_CFG 32'h00000000

`define MAX_WIDTH_MS 7'h63
`define MS_NS 1000000
`define CLK_NS 4
`define MS_CYCLES (`MS_NS / `CLK_NS)

`endif

/* File: sync_trigger_station.v */
// sync trigger station: apb registers, sync-in pulse counting, frame-aligned recording, sync-out pulses
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sync_trigger_station_consts.vh"

module sync_trigger_station #(
    parameter NUM_LINES = 4,
    parameter MS_CYCLES = `MS_CYCLES,
    parameter CYC_W = 18
) (
    input wire clock,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [NUM_LINES-1:0] sync_in,
    input wire frame_tick,
    output reg [NUM_LINES-1:0] sync_out,
    output reg recording
);

    // one counting gate step: returns {act, next count}
    function [8:0] gate_step;
        input [7:0] cnt;
        input [7:0] factor;
        input once;
        input fired;
        begin
            if (cnt != 8'h00) begin
                gate_step = {1'b0, cnt - 8'h01};
            end else if (once && fired) begin
                gate_step = {1'b0, 8'h00};
            end else begin
                gate_step = {1'b1, factor};
            end
        end
    endfunction

    // decoded register address, unmapped gives 3'h7
    function [2:0] reg_index;
        input [7:0] a;
        begin
            case (a)
                `OFS_CTRL: reg_index = 3'h0;
                `OFS_START_IN: reg_index = 3'h1;
                `OFS_STOP_IN: reg_index = 3'h2;
                `OFS_START_OUT: reg_index = 3'h3;
                `OFS_STOP_OUT: reg_index = 3'h4;
                `OFS_STATUS: reg_index = 3'h5;
                `OFS_CMD: reg_index = 3'h6;
                default: reg_index = 3'h7;
            endcase
        end
    endfunction

    function line_hit;
        input [NUM_LINES-1:0] lines;
        input [1:0] sel;
        integer i;
        begin
            line_hit = 1'b0;
            for (i = 0; i < NUM_LINES; i = i + 1) begin
                if (sel == i[1:0]) begin
                    line_hit = lines[i];
                end
            end
        end
    endfunction

    reg [31:0] ctrl_q;
    reg [31:0] in_cfg_q [0:1];
    reg [31:0] out_cfg_q [0:1];
    reg [7:0] in_cnt_q [0:1];
    reg in_fired_q [0:1];
    reg [7:0] out_cnt_q [0:1];
    reg out_fired_q [0:1];
    reg pulse_q [0:1];
    reg [6:0] ms_left_q [0:1];
    reg [CYC_W-1:0] cyc_q [0:1];
    reg [NUM_LINES-1:0] sync_in_prev_q;
    reg start_pend_q;
    reg stop_pend_q;
    reg [7:0] in_pulses_q;

    wire [2:0] idx = reg_index(paddr);
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite & (idx != 3'h7);
    wire arm = ctrl_q[`CTRL_ARM];
    wire rearm = wr & (idx == 3'h0) & pwdata[`CTRL_ARM];
    wire sw_start = wr & (idx == 3'h6) & pwdata[`CMD_START];
    wire sw_stop = wr & (idx == 3'h6) & pwdata[`CMD_STOP];
    wire [NUM_LINES-1:0] rise = sync_in & ~sync_in_prev_q;
    wire [6:0] wr_width = (pwdata[`OUT_WIDTH_LSB+6:`OUT_WIDTH_LSB] > `MAX_WIDTH_MS) ?
        `MAX_WIDTH_MS : pwdata[`OUT_WIDTH_LSB+6:`OUT_WIDTH_LSB];
    wire [31:0] wr_out_cfg = {pwdata[31:15], wr_width, pwdata[7:0]} & `OUT_MASK;

    // read data is loaded in the setup cycle, so no wait state is ever needed
    assign pready = 1'b1;
    assign pslverr = psel & penable & (idx == 3'h7);

    // per-action counting of sync-in pulses; 0 = start, 1 = stop
    reg in_evt [0:1];
    reg [8:0] in_step [0:1];
    reg in_act [0:1];
    reg out_evt [0:1];
    reg [8:0] out_step [0:1];
    reg out_act [0:1];
    reg rec_d;
    // each process keeps its own loop index so no variable has two drivers
    always @* begin : gate_comb
        integer k;
        for (k = 0; k < 2; k = k + 1) begin
            // every pulse looks alike: only the count of the selected line matters
            in_evt[k] = arm & line_hit(rise, in_cfg_q[k][`IN_LINE_LSB+1:`IN_LINE_LSB]);
            in_step[k] = gate_step(in_cnt_q[k], in_cfg_q[k][`IN_FACTOR_LSB+7:`IN_FACTOR_LSB],
                in_cfg_q[k][`IN_ONCE], in_fired_q[k]);
            in_act[k] = in_evt[k] & in_step[k][8];
        end
        rec_d = recording;
        if (frame_tick) begin
            if (recording && stop_pend_q) begin
                rec_d = 1'b0;
            end else if (!recording && start_pend_q) begin
                rec_d = 1'b1;
            end
        end
        out_evt[0] = rec_d & ~recording;
        out_evt[1] = ~rec_d & recording;
        for (k = 0; k < 2; k = k + 1) begin
            out_step[k] = gate_step(out_cnt_q[k], out_cfg_q[k][`OUT_FACTOR_LSB+7:`OUT_FACTOR_LSB],
                out_cfg_q[k][`OUT_ONCE], out_fired_q[k]);
            out_act[k] = out_evt[k] & out_cfg_q[k][`OUT_EN] & out_step[k][8];
        end
    end

    // registers and apb
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `RST_CTRL;
            in_cfg_q[0] <= `RST_IN_CFG;
            in_cfg_q[1] <= `RST_IN_CFG;
            out_cfg_q[0] <= `RST_OUT_CFG;
            out_cfg_q[1] <= `RST_OUT_CFG;
            prdata <= 32'h00000000;
        end else begin
            if (wr) begin
                case (idx)
                    3'h0: ctrl_q <= {31'h00000000, pwdata[`CTRL_ARM]};
                    3'h1: in_cfg_q[0] <= pwdata & `IN_MASK;
                    3'h2: in_cfg_q[1] <= pwdata & `IN_MASK;
                    3'h3: out_cfg_q[0] <= wr_out_cfg;
                    3'h4: out_cfg_q[1] <= wr_out_cfg;
                    default: ;
                endcase
            end
            if (setup) begin
                case (idx)
                    3'h0: prdata <= ctrl_q;
                    3'h1: prdata <= in_cfg_q[0];
                    3'h2: prdata <= in_cfg_q[1];
                    3'h3: prdata <= out_cfg_q[0];
                    3'h4: prdata <= out_cfg_q[1];
                    3'h5: prdata <= {16'h0000, in_pulses_q, 3'h0, pulse_q[1], pulse_q[0],
                        stop_pend_q, start_pend_q, recording};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // trigger counting and frame-aligned recording
    always @(posedge clock or negedge rst_n) begin : trig_count
        integer k;
        if (!rst_n) begin
            // inputs idle low: a line already high at release gives a rising edge, but arm is still clear then, so it is not counted
            sync_in_prev_q <= {NUM_LINES{1'b0}};
            in_cnt_q[0] <= 8'h00;
            in_cnt_q[1] <= 8'h00;
            in_fired_q[0] <= 1'b0;
            in_fired_q[1] <= 1'b0;
            start_pend_q <= 1'b0;
            stop_pend_q <= 1'b0;
            recording <= 1'b0;
            in_pulses_q <= 8'h00;
        end else begin
            sync_in_prev_q <= sync_in;
            recording <= rec_d;
            if (rearm) begin
                for (k = 0; k < 2; k = k + 1) begin
                    in_cnt_q[k] <= pwdata[`CTRL_ARM] ? in_cfg_q[k][`IN_FIRST_LSB+7:`IN_FIRST_LSB] :
                        8'h00;
                    in_fired_q[k] <= 1'b0;
                end
                start_pend_q <= 1'b0;
                stop_pend_q <= 1'b0;
                in_pulses_q <= 8'h00;
            end else begin
                for (k = 0; k < 2; k = k + 1) begin
                    if (in_evt[k]) begin
                        in_cnt_q[k] <= in_step[k][7:0];
                        in_fired_q[k] <= in_fired_q[k] | in_step[k][8];
                    end
                end
                if (in_evt[0] | in_evt[1]) begin
                    in_pulses_q <= in_pulses_q + 8'h01;
                end
                // a trigger in the frame-tick cycle waits for the following frame
                start_pend_q <= (start_pend_q & ~(frame_tick & ~recording)) |
                    ((in_act[0] | sw_start) & ~recording);
                stop_pend_q <= (stop_pend_q & ~(frame_tick & recording)) |
                    ((in_act[1] | sw_stop) & (recording | start_pend_q));
            end
        end
    end

    // sync-out pulse generators; the width counts whole milliseconds from the pulse edge
    // only a rearm, or a new action after a nonzero width is written, ends a zero-width hold
    always @(posedge clock or negedge rst_n) begin : pulse_gen
        integer k;
        if (!rst_n) begin
            for (k = 0; k < 2; k = k + 1) begin
                out_cnt_q[k] <= 8'h00;
                out_fired_q[k] <= 1'b0;
                pulse_q[k] <= 1'b0;
                ms_left_q[k] <= 7'h00;
                cyc_q[k] <= {CYC_W{1'b0}};
            end
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                if (rearm) begin
                    out_cnt_q[k] <= out_cfg_q[k][`OUT_FIRST_LSB+7:`OUT_FIRST_LSB];
                    out_fired_q[k] <= 1'b0;
                    pulse_q[k] <= 1'b0;
                end else if (out_evt[k] & out_cfg_q[k][`OUT_EN]) begin
                    out_cnt_q[k] <= out_step[k][7:0];
                    out_fired_q[k] <= out_fired_q[k] | out_step[k][8];
                    if (out_step[k][8]) begin
                        pulse_q[k] <= 1'b1;
                        ms_left_q[k] <= out_cfg_q[k][`OUT_WIDTH_LSB+6:`OUT_WIDTH_LSB];
                        cyc_q[k] <= {CYC_W{1'b0}};
                    end
                end else if (pulse_q[k] && ms_left_q[k] != 7'h00) begin
                    // zero width never reaches here, so the level holds
                    if (cyc_q[k] == MS_CYCLES - 1) begin
                        cyc_q[k] <= {CYC_W{1'b0}};
                        ms_left_q[k] <= ms_left_q[k] - 7'h01;
                        if (ms_left_q[k] == 7'h01) begin
                            pulse_q[k] <= 1'b0;
                        end
                    end else begin
                        cyc_q[k] <= cyc_q[k] + {{(CYC_W-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end

    // line levels; start action's polarity wins if both actions share a line
    integer j;
    reg [NUM_LINES-1:0] out_d;
    reg neg;
    reg act;
    always @* begin : line_levels
        integer k;
        k = 0;
        for (j = 0; j < NUM_LINES; j = j + 1) begin
            neg = 1'b0;
            act = 1'b0;
            for (k = 1; k >= 0; k = k - 1) begin
                if (out_cfg_q[k][`OUT_LINE_LSB+1:`OUT_LINE_LSB] == j[1:0]) begin
                    neg = out_cfg_q[k][`OUT_NEG];
                    act = act | pulse_q[k];
                end
            end
            out_d[j] = neg ^ act;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= {NUM_LINES{1'b0}};
        end else begin
            sync_out <= out_d;
        end
    end

endmodule // sync_trigger_station

/* File: sts_partner.sv */
// far-side instrument model: sends sync pulses, counts pulses it receives
`timescale 1ns/1ps
module sts_partner (
    input wire clock,
    input wire rst_n,
    input wire fire,
    input wire mon,
    output reg [3:0] sync_in,
    output reg [7:0] seen
);
    reg [1:0] hi_q;
    reg mon_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_in <= 4'h0;
            hi_q <= 2'h0;
            mon_q <= 1'b0;
            seen <= 8'h00;
        end else begin
            // all pulses alike, two cycles high, then low at least one cycle
            sync_in <= {3'h0, fire || hi_q == 2'h2};
            hi_q <= fire ? 2'h2 : (hi_q != 2'h0) ? hi_q - 2'h1 : 2'h0;
            mon_q <= mon;
            if (mon && !mon_q) begin
                seen <= seen + 8'h01; // acts once per received pulse
            end
        end
    end
endmodule // sts_partner

/* File: sts_properties.sv */
// port checker of the sync trigger station
`timescale 1ns/1ps
module sts_properties #(
    parameter NUM_LINES = 4,
    parameter MS_CYCLES = 250000,
    parameter CYC_W = 18
) (
    input wire clock,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [NUM_LINES-1:0] sync_in,
    input wire frame_tick,
    input wire [NUM_LINES-1:0] sync_out,
    input wire recording
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ms phase since last recording change; only valid if changes are ms-aligned
    reg rec_q;
    reg [CYC_W-1:0] ph_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rec_q <= 1'b0;
            ph_q <= '0;
        end else begin
            rec_q <= recording;
            ph_q <= (recording != rec_q) ? {{(CYC_W-1){1'b0}}, 1'b1} :
                (ph_q == MS_CYCLES - 1) ? {CYC_W{1'b0}} : ph_q + 1'b1;
        end
    end
    property p_start_frame;
        $rose(recording) |-> $past(frame_tick);
    endproperty
    a_start_frame: assert property (p_start_frame) else $error("start off frame");
    property p_stop_frame;
        $fell(recording) |-> $past(frame_tick);
    endproperty
    a_stop_frame: assert property (p_stop_frame) else $error("stop off frame");
    property p_out_time;
        $changed(sync_out) |-> ph_q == 1 || $past(psel && penable && pwrite)
            || $past(psel && penable && pwrite, 2);
    endproperty
    a_out_time: assert property (p_out_time) else $error("sync out moved");
    property p_reset_idle;
        !$past(rst_n) |-> sync_out == '0 && !recording;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_err_access;
        pslverr |-> psel && penable;
    endproperty
    a_err_access: assert property (p_err_access) else $error("stray slverr");
    property p_err_map;
        psel && penable && paddr > 8'h18 |-> pslverr;
    endproperty
    a_err_map: assert property (p_err_map) else $error("no slverr");
    c_start: cover property ($rose(recording));
    c_stop: cover property ($fell(recording));
    c_err: cover property (pslverr);
endmodule // sts_properties
bind sync_trigger_station sts_properties #(.NUM_LINES(NUM_LINES), .MS_CYCLES(MS_CYCLES),
    .CYC_W(CYC_W)) i_sts_properties (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_in(sync_in), .frame_tick(frame_tick),
    .sync_out(sync_out), .recording(recording));

/* File: tb_sync_trigger_station.sv */
// self-checking bench of the sync trigger station
`timescale 1ns/1ps
`include "sync_trigger_station_consts.vh"
module tb_sync_trigger_station;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg frame_tick = 1'b0;
    reg fire = 1'b0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [3:0] sync_in;
    wire [3:0] sync_out;
    wire recording;
    wire [7:0] seen;
    reg [31:0] rd;
    reg err;
    integer miscompares = 0;
    integer tests_run = 0;
    integer cyc = 0;
    always #2 clock = ~clock;
    sync_trigger_station #(.MS_CYCLES(10)) i_sync_trigger_station (.clock(clock),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_in(sync_in), .frame_tick(frame_tick), .sync_out(sync_out),
        .recording(recording));
    sts_partner i_sts_partner (.clock(clock), .rst_n(rst_n), .fire(fire),
        .mon(sync_out[2]), .sync_in(sync_in), .seen(seen));
    task test_done;
        begin
            $display("run %0d miscompares %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // frame of 40 cycles, a whole number of shortened milliseconds
    always @(posedge clock) begin
        cyc <= cyc + 1;
        frame_tick <= (cyc % 40 == 39);
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            test_done;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task xfer(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            @(posedge clock);
            while (pready !== 1'b1) @(posedge clock);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdchk(input [7:0] a, input [31:0] exp);
        begin
            xfer(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask
    task wait_rec(input v);
        integer i;
        begin
            for (i = 0; i < 100 && recording !== v; i = i + 1) @(posedge clock);
            chk(recording, v);
        end
    endtask
    // one sync pulse just after a frame start; recording must wait for the next one
    task pulse(input v);
        begin
            @(posedge clock);
            while (frame_tick !== 1'b1) @(posedge clock);
            fire <= 1'b1;
            @(posedge clock);
            fire <= 1'b0;
            repeat (10) @(posedge clock);
            chk(recording, !v);
            wait_rec(v);
        end
    endtask
    // one sync pulse at any time, then more than a frame of waiting
    task kick;
        begin
            @(posedge clock);
            fire <= 1'b1;
            @(posedge clock);
            fire <= 1'b0;
            repeat (60) @(posedge clock);
        end
    endtask
    task width(input [1:0] l, input act, input [31:0] exp);
        integer n;
        begin
            n = 0;
            while (n < 100 && sync_out[l] !== act) begin
                @(posedge clock);
                n = n + 1;
            end
            n = 0;
            while (n < 2000 && sync_out[l] === act) begin
                @(posedge clock);
                n = n + 1;
            end
            chk(n, exp);
        end
    endtask
    task t_reset;
        begin
            chk(sync_out, 4'h0);
            rdchk(`OFS_CTRL, `RST_CTRL);
            rdchk(8'h1c, 32'h0);
            chk(err, 1'b1);
        end
    endtask
    task t_shared;
        begin
            wr(`OFS_START_IN, 32'h00010000);
            wr(`OFS_STOP_IN, 32'h00010100);
            // widths of 10 and 20 cycles stay inside one 40-cycle frame
            wr(`OFS_START_OUT, 32'h00000142);
            wr(`OFS_STOP_OUT, 32'h00000253);
            wr(`OFS_CTRL, 32'h1);
            repeat (2) @(posedge clock);
            chk(sync_out, 4'h8);
            pulse(1'b1);
            width(2'd2, 1'b1, 10);
            pulse(1'b0);
            width(2'd3, 1'b0, 20);
            pulse(1'b1);
            width(2'd2, 1'b1, 10);
            chk(seen, 8'h02);
            rdchk(`OFS_STATUS, 32'h00000301);
        end
    endtask
    task t_hold;
        begin
            wr(`OFS_CMD, 32'h2);
            wait_rec(1'b0);
            wr(`OFS_START_OUT, 32'h00000042);
            wr(`OFS_CTRL, 32'h1);
            wr(`OFS_CMD, 32'h1);
            wait_rec(1'b1);
            repeat (1200) @(posedge clock);
            chk(sync_out[2], 1'b1);
            wr(`OFS_CTRL, 32'h1);
            repeat (2) @(posedge clock);
            chk(sync_out[2], 1'b0);
        end
    endtask
    task t_once;
        begin
            wr(`OFS_START_OUT, 32'h00007f62);
            rdchk(`OFS_START_OUT, 32'h00006362);
            wr(`OFS_START_OUT, 32'h00000162);
            wr(`OFS_CMD, 32'h2);
            wait_rec(1'b0);
            wr(`OFS_CTRL, 32'h1);
            wr(`OFS_CMD, 32'h1);
            wait_rec(1'b1);
            width(2'd2, 1'b1, 10);
            wr(`OFS_CMD, 32'h2);
            wait_rec(1'b0);
            wr(`OFS_CMD, 32'h1);
            wait_rec(1'b1);
            repeat (20) @(posedge clock);
            chk(sync_out[2], 1'b0);
        end
    endtask
    // input-side single start, then disarmed: later pulses change nothing
    task t_in_once;
        begin
            wr(`OFS_CMD, 32'h2);
            wait_rec(1'b0);
            wr(`OFS_START_IN, 32'h01010000);
            wr(`OFS_CTRL, 32'h1);
            pulse(1'b1);
            pulse(1'b0);
            kick;
            chk(recording, 32'h0);
            rdchk(`OFS_STATUS, 32'h00000300);
            wr(`OFS_CTRL, 32'h0);
            kick;
            rdchk(`OFS_STATUS, 32'h00000300);
        end
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_shared;
        t_hold;
        t_once;
        t_in_once;
        test_done;
    end
endmodule // tb_sync_trigger_station
